// ==== pkg/tag_cmd_pkg.sv ====
/*
 * Constants and carriers for the Type B tag command handler.
 * Assumes framing and CRC are handled outside; bytes arrive one per beat.
 */
`default_nettype none
package tag_cmd_pkg;
    localparam logic [7:0]  ATTRIB_RESP   = 8'h10;
    localparam logic [7:0]  HALT_CMD      = 8'h50;
    localparam logic [7:0]  HALT_RESP     = 8'h00;
    localparam logic [7:0]  CLA_OK        = 8'h00;
    localparam logic [7:0]  INS_SELECT    = 8'hA4;
    localparam logic [7:0]  INS_READ      = 8'hB0;
    localparam logic [15:0] PP_EF         = 16'h020C;
    localparam logic [15:0] PP_APP        = 16'h0400;
    localparam logic [15:0] PP_FILE       = 16'h000C;
    localparam logic [7:0]  P2_NO_FCI     = 8'h0C;
    localparam logic [7:0]  LC_APP        = 8'h07;
    localparam logic [7:0]  LC_FILE       = 8'h02;
    localparam logic [55:0] AID_NDEF      = 56'hD2760000850101;
    localparam logic [15:0] FID_CC        = 16'hE103;
    localparam logic [15:0] FID_NDEF      = 16'h0103;
    localparam logic [7:0]  LE_APP        = 8'h00;
    localparam logic [7:0]  LE_MIN        = 8'h01;
    localparam logic [7:0]  LE_MAX        = 8'hFB;
    localparam logic [15:0] SW_OK_DEF     = 16'h9000;
    localparam logic [15:0] SW_ERR_DEF    = 16'h6A82;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          FIFO_WIDTH    = 9;
    localparam logic [3:0]  CNT_ONE       = 4'h1;

    typedef enum logic [1:0] {
        SEL_NONE, SEL_APP, SEL_CC, SEL_NDEF
    } file_sel_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
    } byte_beat_s;
endpackage : tag_cmd_pkg
`default_nettype wire

// ==== rtl/tag_fifo.sv ====
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock, asynchronous active-high reset.
 */
`default_nettype none
module tag_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem[rd_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) mem[wr_q[AW-1:0]] <= in_data;
    end
endmodule : tag_fifo
`default_nettype wire

// ==== rtl/typeb_tag_command_handler.sv ====
/*
 * Command interpreter for a Type B tag: ATTRIB answer, halt, file
 * selection and read. Assumes the framer delivers CRC-checked command
 * bytes with a last flag, and appends CRC to answer bytes.
 */
`default_nettype none
module typeb_tag_command_handler (
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    input  wire logic [31:0]            own_pupi,
    input  wire logic                   tunnel_mode,
    input  wire logic [15:0]            sw_ok,
    input  wire logic [15:0]            sw_err,
    input  wire logic                   attrib_ok,
    input  wire tag_cmd_pkg::byte_beat_s rx,
    output logic                        rx_ready,
    output logic                        mem_req,
    output logic                        host_req,
    output logic [15:0]                 rd_addr,
    input  wire logic                   rd_valid,
    input  wire logic [7:0]             rd_data,
    output tag_cmd_pkg::byte_beat_s     tx,
    input  wire logic                   tx_ready,
    output logic                        halted,
    output tag_cmd_pkg::file_sel_e      file_sel
);
    typedef enum logic [2:0] {
        ST_RX, ST_EVAL, ST_FETCH, ST_SW1, ST_SW2, ST_ONE
    } phase_e;

    typedef struct packed {
        phase_e                 phase;
        logic [7:0]             idx;
        logic [7:0]             cla;
        logic [7:0]             ins;
        logic [15:0]            pp;
        logic [7:0]             lc;
        logic [55:0]            dat;
        logic [7:0]             le;
        logic                   has_le;
        logic [7:0]             left;
        logic [7:0]             issued;
        logic [15:0]            addr;
        logic [15:0]            sw;
        logic [7:0]             one;
        logic                   halted;
        tag_cmd_pkg::file_sel_e sel;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic   f_in_ready;
    logic   f_out_valid;
    logic   f_push;
    logic   f_pop;
    logic [8:0] f_in;
    logic [8:0] f_out;
    logic   sel_good;
    logic   sel_len;
    logic   read_good;
    logic   room;
    tag_cmd_pkg::file_sel_e sel_new;

    tag_fifo #(
        .WIDTH (tag_cmd_pkg::FIFO_WIDTH),
        .DEPTH (tag_cmd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .in_valid  (f_push),
        .in_ready  (f_in_ready),
        .in_data   (f_in),
        .out_valid (f_out_valid),
        .out_ready (f_pop),
        .out_data  (f_out)
    );

    // Frame length must match Lc so stale fields of a short frame never pass
    assign sel_len = s_q.idx == 8'h05 + s_q.lc + {7'h00, s_q.has_le};

    // Selection and read checks on the captured fields
    always_comb begin
        sel_good = 1'b0;
        sel_new  = s_q.sel;
        if (s_q.cla == tag_cmd_pkg::CLA_OK) begin
            if (s_q.pp == tag_cmd_pkg::PP_APP) begin
                sel_good = s_q.lc == tag_cmd_pkg::LC_APP && sel_len
                    && s_q.dat == tag_cmd_pkg::AID_NDEF
                    && (!s_q.has_le
                        || s_q.le == tag_cmd_pkg::LE_APP);
                sel_new = tag_cmd_pkg::SEL_APP;
            end else if (s_q.pp == tag_cmd_pkg::PP_EF) begin
                sel_good = s_q.lc == tag_cmd_pkg::LC_FILE && !s_q.has_le
                    && sel_len;
                sel_new  = tag_cmd_pkg::SEL_NONE;
            end else if (s_q.pp == tag_cmd_pkg::PP_FILE) begin
                sel_good = s_q.lc == tag_cmd_pkg::LC_FILE && !s_q.has_le
                    && sel_len;
                // Identifiers other than CC and NDEF are a plain EF choice
                if (s_q.dat[15:0] == tag_cmd_pkg::FID_CC) begin
                    sel_new = tag_cmd_pkg::SEL_CC;
                end else if (s_q.dat[15:0] == tag_cmd_pkg::FID_NDEF) begin
                    sel_new = tag_cmd_pkg::SEL_NDEF;
                end else begin
                    sel_new = tag_cmd_pkg::SEL_NONE;
                end
            end
        end
        read_good = s_q.cla == tag_cmd_pkg::CLA_OK && s_q.idx == 8'h05
            && s_q.le >= tag_cmd_pkg::LE_MIN
            && s_q.le <= tag_cmd_pkg::LE_MAX;
    end

    assign rx_ready = s_q.phase == phase_e'(ST_RX);
    // Requested but not yet sent bytes, in flight included, fit the FIFO
    assign room     = (s_q.left - s_q.issued)
        < 8'(tag_cmd_pkg::FIFO_DEPTH) && f_in_ready;
    assign mem_req  = s_q.phase == ST_FETCH && s_q.issued != 8'h00
        && room && !tunnel_mode;
    assign host_req = s_q.phase == ST_FETCH && s_q.issued != 8'h00
        && room && tunnel_mode;
    assign rd_addr  = s_q.addr;
    assign f_push   = rd_valid && s_q.phase == ST_FETCH;
    assign f_in     = {1'b0, rd_data};
    assign f_pop    = s_q.phase == ST_FETCH && f_out_valid && tx_ready;
    assign halted   = s_q.halted;
    assign file_sel = s_q.sel;

    always_comb begin
        s_d = s_q;
        tx  = '0;
        case (s_q.phase)
            ST_RX: begin
                if (rx.valid) begin
                    s_d.idx = s_q.idx + 8'h01;
                    case (s_q.idx)
                        8'h00: s_d.cla = rx.data;
                        8'h01: s_d.ins = rx.data;
                        8'h02: s_d.pp[15:8] = rx.data;
                        8'h03: s_d.pp[7:0] = rx.data;
                        8'h04: begin
                            s_d.lc = rx.data;
                            s_d.le = rx.data;
                        end
                        default: begin
                            if (s_q.idx - 8'h05 < s_q.lc
                                    && s_q.idx < 8'h0C) begin
                                s_d.dat = {s_q.dat[47:0], rx.data};
                            end else begin
                                s_d.le     = rx.data;
                                s_d.has_le = 1'b1;
                            end
                        end
                    endcase
                    if (rx.last) s_d.phase = ST_EVAL;
                end
            end
            ST_EVAL: begin
                s_d.idx    = 8'h00;
                s_d.has_le = 1'b0;
                s_d.dat    = '0;
                s_d.sw     = sw_err;
                s_d.phase  = ST_SW1;
                if (s_q.idx == 8'h05 && s_q.cla == tag_cmd_pkg::HALT_CMD) begin
                    // Halt: code byte then identifier in cla..lc order
                    if ({s_q.ins, s_q.pp, s_q.lc} == own_pupi) begin
                        s_d.halted = 1'b1;
                        s_d.one    = tag_cmd_pkg::HALT_RESP;
                        s_d.phase  = ST_ONE;
                    end else begin
                        s_d.phase = ST_RX;
                    end
                end else if (s_q.idx == 8'h01 && attrib_ok) begin
                    s_d.one   = tag_cmd_pkg::ATTRIB_RESP;
                    s_d.phase = ST_ONE;
                end else if (s_q.ins == tag_cmd_pkg::INS_SELECT) begin
                    if (sel_good) begin
                        s_d.sel = sel_new;
                        s_d.sw  = sw_ok;
                    end
                end else if (s_q.ins == tag_cmd_pkg::INS_READ && read_good) begin
                    s_d.addr   = s_q.pp;
                    s_d.left   = s_q.le;
                    s_d.issued = s_q.le;
                    s_d.sw     = sw_ok;
                    s_d.phase  = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (mem_req || host_req) begin
                    s_d.addr   = s_q.addr + 16'h0001;
                    s_d.issued = s_q.issued - 8'h01;
                end
                tx.valid = f_out_valid;
                tx.data  = f_out[7:0];
                if (f_pop) begin
                    s_d.left = s_q.left - 8'h01;
                    if (s_q.left == 8'h01) s_d.phase = ST_SW1;
                end
            end
            ST_SW1: begin
                // Select with P2 0x0C carries no control information
                tx.valid = 1'b1;
                tx.data  = s_q.sw[15:8];
                if (tx_ready) s_d.phase = ST_SW2;
            end
            ST_SW2: begin
                tx.valid = 1'b1;
                tx.data  = s_q.sw[7:0];
                tx.last  = 1'b1;
                if (tx_ready) s_d.phase = ST_RX;
            end
            ST_ONE: begin
                tx.valid = 1'b1;
                tx.data  = s_q.one;
                tx.last  = 1'b1;
                if (tx_ready) s_d.phase = ST_RX;
            end
            default: s_d.phase = ST_RX;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    sel_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
        s_q.phase == ST_EVAL && s_q.ins == tag_cmd_pkg::INS_SELECT
        && !sel_good && s_q.cla != tag_cmd_pkg::HALT_CMD
        |=> s_q.sel == $past(s_q.sel) && s_q.sw == $past(sw_err))
        else $error("rejected select changed selection");
    cla_err_a: assert property (@(posedge ref_clk) disable iff (reset)
        s_q.phase == ST_EVAL && s_q.cla != tag_cmd_pkg::CLA_OK
        && s_q.idx > 8'h01 |=> s_q.phase != ST_FETCH)
        else $error("bad class byte accepted");
    halt_go_a: assert property (@(posedge ref_clk) disable iff (reset)
        s_q.phase == ST_EVAL && s_q.idx == 8'h05
        && s_q.cla == tag_cmd_pkg::HALT_CMD
        && {s_q.ins, s_q.pp, s_q.lc} == own_pupi
        |=> halted && s_q.phase == ST_ONE)
        else $error("halt not taken");
    halt_resp_a: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(halted) |-> tx.valid && tx.data == tag_cmd_pkg::HALT_RESP
        && tx.last)
        else $error("halt answer wrong");
    attrib_resp_a: assert property (@(posedge ref_clk) disable iff (reset)
        s_q.phase == ST_EVAL && s_q.idx == 8'h01 && attrib_ok
        && s_q.cla != tag_cmd_pkg::HALT_CMD
        |=> tx.valid && tx.data == tag_cmd_pkg::ATTRIB_RESP)
        else $error("attrib answer wrong");
    sel_app_a: assert property (@(posedge ref_clk) disable iff (reset)
        s_q.phase == ST_EVAL && s_q.ins == tag_cmd_pkg::INS_SELECT
        && s_q.idx > 8'h01 && s_q.pp == tag_cmd_pkg::PP_APP
        && s_q.lc != tag_cmd_pkg::LC_APP |=> s_q.sw == $past(sw_err))
        else $error("bad select length accepted");
    read_addr_a: assert property (@(posedge ref_clk) disable iff (reset)
        s_q.phase == ST_EVAL && s_q.ins == tag_cmd_pkg::INS_READ
        && read_good && s_q.idx > 8'h01
        |=> rd_addr == $past(s_q.pp) && s_q.left == $past(s_q.le))
        else $error("read address not loaded");
    read_err_a: assert property (@(posedge ref_clk) disable iff (reset)
        s_q.phase == ST_EVAL && s_q.ins == tag_cmd_pkg::INS_READ
        && !read_good && s_q.idx > 8'h01
        && s_q.cla != tag_cmd_pkg::HALT_CMD
        |=> s_q.phase == ST_SW1 && s_q.sw == $past(sw_err))
        else $error("data sent with error status");
    tunnel_src_a: assert property (@(posedge ref_clk) disable iff (reset)
        tunnel_mode |-> !mem_req)
        else $error("memory read during tunnel mode");

    halt_c: cover property (@(posedge ref_clk) disable iff (reset)
        $rose(halted));
    sel_c: cover property (@(posedge ref_clk) disable iff (reset)
        s_q.phase == ST_EVAL && sel_good);
    read_c: cover property (@(posedge ref_clk) disable iff (reset)
        s_q.phase == ST_FETCH ##1 s_q.phase == ST_SW1);
endmodule : typeb_tag_command_handler
`default_nettype wire

// ==== bench/mem_model.sv ====
/*
 * Memory and tunnel host responder for the tag command handler bench.
 * Assumes one byte request per cycle on mem_req or host_req at rd_addr.
 */
`default_nettype none
module mem_model (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic        host_req,
    input  wire logic [15:0] rd_addr,
    output logic             rd_valid,
    output logic      [7:0]  rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [16:0] pend[$];
    logic [16:0] head;
    int          seed = 11;
    // Host and memory contents differ so a wrong source shows
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pend.delete();
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
        end else begin
            if (pend.size() > 0 && (!slow || $random(seed) % 4 == 0)) begin
                head = pend.pop_front();
                rd_valid <= 1'b1;
                rd_data  <= head[16] ? head[7:0] ^ 8'h5A
                                     : head[7:0] + head[15:8];
            end else begin
                rd_valid <= 1'b0;
                // No stale byte between answers
                rd_data  <= ~rd_data;
            end
            if (mem_req || host_req)
                pend.push_back({host_req, rd_addr});
        end
    end
endmodule : mem_model
`default_nettype wire

// ==== bench/tb.sv ====
/*
 * Self-checking bench for the Type B tag command handler.
 * Assumes the handler contract: bytes taken on rx_ready, answers on tx.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [7:0] bq_t[$];
    logic                    ref_clk;
    logic                    reset;
    logic [31:0]             own_pupi;
    logic                    tunnel_mode;
    logic [15:0]             sw_ok;
    logic [15:0]             sw_err;
    logic                    attrib_ok;
    tag_cmd_pkg::byte_beat_s rx;
    logic                    rx_ready;
    logic                    mem_req;
    logic                    host_req;
    logic [15:0]             rd_addr;
    logic                    rd_valid;
    logic [7:0]              rd_data;
    tag_cmd_pkg::byte_beat_s tx;
    logic                    tx_ready;
    logic                    halted;
    tag_cmd_pkg::file_sel_e  file_sel;
    logic                    slow;
    tag_cmd_pkg::file_sel_e  cur_sel;
    int                      seed = 50695;
    int                      n_errors = 0;
    int                      checked = 0;
    bq_t                     resp;
    bq_t                     q;

    typeb_tag_command_handler dut (.ref_clk(ref_clk), .reset(reset),
        .own_pupi(own_pupi), .tunnel_mode(tunnel_mode), .sw_ok(sw_ok),
        .sw_err(sw_err), .attrib_ok(attrib_ok), .rx(rx),
        .rx_ready(rx_ready), .mem_req(mem_req), .host_req(host_req),
        .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
        .tx(tx), .tx_ready(tx_ready), .halted(halted), .file_sel(file_sel));
    mem_model partner (.ref_clk(ref_clk), .reset(reset), .slow(slow),
        .mem_req(mem_req), .host_req(host_req), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_data(rd_data));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Answer side stalls about one cycle in three
    always @(posedge ref_clk) tx_ready <= ($random(seed) % 3 != 0);

    function automatic logic [7:0] exp_byte(input logic h,
                                            input logic [15:0] a);
        return h ? a[7:0] ^ 8'h5A : a[7:0] + a[15:8];
    endfunction : exp_byte

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic send(input bq_t f);
        for (int i = 0; i < f.size(); i++) begin
            rx <= '{valid: 1'b1, data: f[i], last: i == f.size() - 1};
            @(negedge ref_clk);
            while (rx_ready !== 1'b1) @(negedge ref_clk);
            @(posedge ref_clk);
        end
        rx <= '0;
    endtask : send

    task automatic collect(input int limit);
        resp.delete();
        for (int n = 0; n < limit; n++) begin
            @(negedge ref_clk);
            if (tx.valid === 1'b1 && tx_ready === 1'b1) begin
                resp.push_back(tx.data);
                if (tx.last === 1'b1) break;
            end
        end
        @(posedge ref_clk);
    endtask : collect

    task automatic expect_resp(input string what, input bq_t e);
        chk({what, " length"}, 16'(e.size()), 16'(resp.size()));
        foreach (e[i])
            if (i < resp.size()) chk(what, {8'h00, e[i]}, {8'h00, resp[i]});
    endtask : expect_resp

    task automatic do_halt(input logic [31:0] id, input logic own);
        bq_t f;
        bq_t e;
        f = {tag_cmd_pkg::HALT_CMD, id[31:24], id[23:16], id[15:8], id[7:0]};
        if (own) e.push_back(tag_cmd_pkg::HALT_RESP);
        send(f);
        collect(own ? 200 : 40);
        expect_resp("halt answer", e);
        chk("halted", 16'(own), 16'(halted));
    endtask : do_halt

    task automatic do_sel(input logic [7:0] cla, input logic [15:0] pp,
                          input logic [7:0] lc, input logic [55:0] d,
                          input int nd, input int le, input logic ok,
                          input tag_cmd_pkg::file_sel_e sel);
        bq_t         f;
        bq_t         e;
        logic [15:0] sw;
        f = {cla, tag_cmd_pkg::INS_SELECT, pp[15:8], pp[7:0], lc};
        for (int i = nd - 1; i >= 0; i--) f.push_back(d[i*8 +: 8]);
        if (le >= 0) f.push_back(le[7:0]);
        sw = ok ? sw_ok : sw_err;
        e = {sw[15:8], sw[7:0]};
        if (ok) cur_sel = sel;
        send(f);
        collect(200);
        expect_resp("select answer", e);
        chk("file selection", 16'(cur_sel), 16'(file_sel));
    endtask : do_sel

    task automatic do_read(input logic [7:0] cla, input logic [15:0] a,
                           input logic [7:0] le, input logic t);
        bq_t         e;
        logic [15:0] sw;
        logic        ok;
        tunnel_mode <= t;
        slow        <= $random(seed) % 2 == 0;
        ok = cla === tag_cmd_pkg::CLA_OK && le >= tag_cmd_pkg::LE_MIN
            && le <= tag_cmd_pkg::LE_MAX;
        sw = ok ? sw_ok : sw_err;
        if (ok)
            for (int i = 0; i < le; i++) e.push_back(exp_byte(t, a + 16'(i)));
        e.push_back(sw[15:8]);
        e.push_back(sw[7:0]);
        send({cla, tag_cmd_pkg::INS_READ, a[15:8], a[7:0], le});
        collect(3000);
        expect_resp("read answer", e);
    endtask : do_read

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    initial begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        reset = 1'b1;
        rx = '0;
        tunnel_mode = 1'b0;
        attrib_ok = 1'b0;
        slow = 1'b0;
        sw_ok = tag_cmd_pkg::SW_OK_DEF;
        sw_err = tag_cmd_pkg::SW_ERR_DEF;
        own_pupi = $random(seed);
        cur_sel = tag_cmd_pkg::SEL_NONE;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        attrib_ok <= 1'b1;
        send({8'h1D});
        collect(200);
        q = {tag_cmd_pkg::ATTRIB_RESP};
        expect_resp("attrib answer", q);
        attrib_ok <= 1'b0;
        $display("test attrib finished");
        do_halt(own_pupi ^ 32'h0000_0100, 1'b0);
        do_halt(own_pupi, 1'b1);
        $display("test halt finished");
        do_sel(8'h00, tag_cmd_pkg::PP_APP, tag_cmd_pkg::LC_APP,
               tag_cmd_pkg::AID_NDEF, 7, 0, 1'b1, tag_cmd_pkg::SEL_APP);
        do_sel(8'h00, tag_cmd_pkg::PP_FILE, tag_cmd_pkg::LC_FILE,
               56'(tag_cmd_pkg::FID_CC), 2, -1, 1'b1, tag_cmd_pkg::SEL_CC);
        do_sel(8'h01, tag_cmd_pkg::PP_FILE, tag_cmd_pkg::LC_FILE,
               56'(tag_cmd_pkg::FID_NDEF), 2, -1, 1'b0, cur_sel);
        do_sel(8'h00, 16'h0100, tag_cmd_pkg::LC_FILE,
               56'(tag_cmd_pkg::FID_NDEF), 2, -1, 1'b0, cur_sel);
        do_sel(8'h00, tag_cmd_pkg::PP_APP, 8'h06,
               tag_cmd_pkg::AID_NDEF >> 8, 6, 0, 1'b0, cur_sel);
        do_sel(8'h00, tag_cmd_pkg::PP_APP, tag_cmd_pkg::LC_APP,
               tag_cmd_pkg::AID_NDEF ^ 56'h1, 7, 0, 1'b0, cur_sel);
        do_sel(8'h00, tag_cmd_pkg::PP_APP, tag_cmd_pkg::LC_APP,
               tag_cmd_pkg::AID_NDEF, 7, 1, 1'b0, cur_sel);
        do_sel(8'h00, tag_cmd_pkg::PP_FILE, tag_cmd_pkg::LC_FILE,
               56'h1234, 2, -1, 1'b1, tag_cmd_pkg::SEL_NONE);
        do_sel(8'h00, tag_cmd_pkg::PP_FILE, tag_cmd_pkg::LC_FILE,
               56'(tag_cmd_pkg::FID_NDEF), 2, -1, 1'b1, tag_cmd_pkg::SEL_NDEF);
        do_sel(8'h00, tag_cmd_pkg::PP_EF, tag_cmd_pkg::LC_FILE,
               56'h1234, 2, 0, 1'b0, cur_sel);
        do_sel(8'h00, tag_cmd_pkg::PP_EF, tag_cmd_pkg::LC_FILE,
               56'($random(seed) & 16'hFFFF), 2, -1, 1'b1,
               tag_cmd_pkg::SEL_NONE);
        $display("test select finished");
        do_read(8'h00, 16'h0180, 8'h01, 1'b0);
        do_read(8'h00, 16'hFE00, tag_cmd_pkg::LE_MAX, 1'b0);
        do_read(8'h80, 16'h0010, 8'h04, 1'b0);
        do_read(8'h00, 16'h0030, 8'h00, 1'b0);
        do_read(8'h00, 16'h0020, 8'hF0, 1'b1);
        $display("test read corners finished");
        for (int k = 0; k < 12; k++)
            do_read(8'h00, 16'($random(seed)),
                    8'(1 + {$random(seed)} % 251), 1'($random(seed)));
        $display("test random reads finished");
        summarize();
    end
endmodule : tb
`default_nettype wire
